// *** core/sosq_defs.svh ***
/*
  Constants of the single-operand cycle sequencer: opcodes, addressing
  modes, register numbers, reset values and field positions.
  Assumes one 100 MHz core clock and a word-wide memory on the same clock.
*/
// Function
// - Each instruction starts with a read at the program counter and then one idle decode cycle.
// - After decode the operand-derivation sub-sequence for the source mode is inserted.
// - The modify-in-place group spends one idle cycle and then writes the result to the source address.
// - Clear and set-ones still fetch the operand although it is ignored.
// - Absolute value tests the operand and skips straight to the final idle cycle when its sign bit is clear (positive or zero).
// - A negative absolute-value operand is negated and written back to the source address.
// - Both absolute-value paths end with an idle cycle that keeps the address bus.
// - Execute-indirect runs the fetched operand as an instruction, starting at its decode cycle.
// - Branch fetches and drops the operand, then ends with one idle cycle.
// - Branch-and-link drives the link register address and then writes the return address there.
// - The context switch drives new register 15 and then writes the old status into it.
// - The context switch then idles and writes the return address into new register 14.
// - It then drives new register 13, writes the old workspace pointer into it, idles, reads the new PC, and idles.
`ifndef SOSQ_DEFS_SVH
`define SOSQ_DEFS_SVH

`define SOSQ_OP_HI 15
`define SOSQ_OP_LO 6
`define SOSQ_SRC_HI 5
`define SOSQ_SRC_LO 0
`define SOSQ_OP_CTXSW 10'h010
`define SOSQ_OP_BRANCH 10'h011
`define SOSQ_OP_EXEC 10'h012
`define SOSQ_OP_CLEAR 10'h013
`define SOSQ_OP_NEGATE 10'h014
`define SOSQ_OP_INVERT 10'h015
`define SOSQ_OP_INC 10'h016
`define SOSQ_OP_INC2 10'h017
`define SOSQ_OP_DEC 10'h018
`define SOSQ_OP_DEC2 10'h019
`define SOSQ_OP_BLINK 10'h01a
`define SOSQ_OP_SETONE 10'h01c
`define SOSQ_OP_ABS 10'h01d

`define SOSQ_MODE_REG 2'h0
`define SOSQ_MODE_IND 2'h1
`define SOSQ_MODE_IDX 2'h2
`define SOSQ_MODE_AUTO 2'h3

`define SOSQ_WR_LINK 4'hb
`define SOSQ_WR_OLDST 4'hf
`define SOSQ_WR_OLDPC 4'he
`define SOSQ_WR_OLDWP 4'hd

`define SOSQ_WORD_STEP 16'h0002
`define SOSQ_ONE 16'h0001
`define SOSQ_ALL_ONES 16'hffff
`define SOSQ_ZERO 16'h0000
`define SOSQ_SIGN_BIT 15
`define SOSQ_RST_PC 16'h0000
`define SOSQ_RST_WP 16'h0000

`endif

// *** core/sosq_pkg.sv ***
/*
  Types of the single-operand cycle sequencer: bus carrier, source
  operand selector, state enumerations and the register address helper.
  Assumes sosq_defs.svh for numeric constants.
*/
package sosq_pkg;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // One memory cycle as seen on the processor bus.
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd;
    logic wr;
  } sosq_bus_t;

  // Source addressing mode and register number of an instruction.
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] reg_n;
  } sosq_src_t;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    S_FETCH = 5'b00000, S_DECODE = 5'b00001, S_DERIVE = 5'b00010,
    S_EXEC = 5'b00011, S_WRBACK = 5'b00100, S_ABS_TEST = 5'b00101,
    S_ABS_NEG = 5'b00110, S_ABS_WR = 5'b00111, S_ABS_END = 5'b01000,
    S_BL_ADDR = 5'b01001, S_BL_WR = 5'b01010, S_CS_A15 = 5'b01011,
    S_CS_W15 = 5'b01100, S_CS_I6 = 5'b01101, S_CS_W14 = 5'b01110,
    S_CS_A13 = 5'b01111, S_CS_W13 = 5'b10000, S_CS_I10 = 5'b10001,
    S_CS_RDPC = 5'b10010, S_CS_END = 5'b10011
  } sosq_state_t;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_RD_PTR = 3'b001, D_WR_INC = 3'b010,
    D_RD_EXT = 3'b011, D_RD_IDX = 3'b100, D_RD_OPD = 3'b101
  } sosq_dstate_t;

  // Workspace register n lives at the pointer plus twice n.
  function automatic logic [15:0] sosq_wr_addr(input logic [15:0] wp, input logic [3:0] n);
    sosq_wr_addr = wp + {11'h000, n, 1'b0};
  endfunction

endpackage

// *** core/sosq_derive.sv ***
/*
  Operand-derivation sub-sequence: register, indirect, indexed and
  auto-increment source modes, word operands only.
  Assumes the caller holds wp stable while it runs, advances pc on o_pc_adv, and muxes
  o_bus onto the memory bus; its last read is always at the source address.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sosq_defs.svh"

module sosq_derive (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Request from the sequencer.
  input wire logic i_start,
  input wire sosq_pkg::sosq_src_t i_src,
  input wire logic [15:0] i_wp,
  input wire logic [15:0] i_pc,
  // Memory side.
  input wire logic [15:0] i_rdata,
  output sosq_pkg::sosq_bus_t o_bus,
  // Completion.
  output logic o_done,
  output logic o_pc_adv
);
  import sosq_pkg::*;

  sosq_dstate_t st_r, st_nxt;
  sosq_bus_t bus_r, bus_nxt;
  sosq_src_t src_r, src_nxt;
  logic [15:0] ptr_r, ptr_nxt;

  // Next cycle of the sub-sequence; each branch sets up the following bus cycle.
  always_comb begin
    st_nxt = st_r;
    src_nxt = src_r;
    ptr_nxt = ptr_r;
    bus_nxt = bus_r;
    bus_nxt.rd = 1'b0;
    bus_nxt.wr = 1'b0;
    o_done = 1'b0;
    o_pc_adv = 1'b0;
    case (st_r)
      D_IDLE: begin
        if (i_start) begin
          src_nxt = i_src;
          bus_nxt.rd = 1'b1;
          bus_nxt.addr = sosq_wr_addr(i_wp, i_src.reg_n);
          case (i_src.mode)
            `SOSQ_MODE_REG: st_nxt = D_RD_OPD;
            `SOSQ_MODE_IDX: begin
              st_nxt = D_RD_EXT;
              bus_nxt.addr = i_pc;
            end
            default: st_nxt = D_RD_PTR;
          endcase
        end
      end
      D_RD_PTR: begin
        ptr_nxt = i_rdata;
        if (src_r.mode == `SOSQ_MODE_AUTO) begin
          st_nxt = D_WR_INC;
          bus_nxt.wr = 1'b1;
          bus_nxt.wdata = i_rdata + `SOSQ_WORD_STEP;
        end else begin
          st_nxt = D_RD_OPD;
          bus_nxt.rd = 1'b1;
          bus_nxt.addr = i_rdata;
        end
      end
      D_WR_INC: begin
        st_nxt = D_RD_OPD;
        bus_nxt.rd = 1'b1;
        bus_nxt.addr = ptr_r;
      end
      D_RD_EXT: begin
        // The extension word consumes a program word.
        o_pc_adv = 1'b1;
        ptr_nxt = i_rdata;
        bus_nxt.rd = 1'b1;
        if (src_r.reg_n != 4'h0) begin
          st_nxt = D_RD_IDX;
          bus_nxt.addr = sosq_wr_addr(i_wp, src_r.reg_n);
        end else begin
          st_nxt = D_RD_OPD;
          bus_nxt.addr = i_rdata;
        end
      end
      D_RD_IDX: begin
        st_nxt = D_RD_OPD;
        bus_nxt.rd = 1'b1;
        bus_nxt.addr = ptr_r + i_rdata;
      end
      D_RD_OPD: begin
        // Operand fetch is never skipped, even when the caller ignores it.
        o_done = 1'b1;
        st_nxt = D_IDLE;
      end
      default: st_nxt = D_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= D_IDLE;
      src_r <= '0;
      ptr_r <= `SOSQ_ZERO;
      bus_r <= '0;
    end else begin
      st_r <= st_nxt;
      src_r <= src_nxt;
      ptr_r <= ptr_nxt;
      bus_r <= bus_nxt;
    end
  end

  assign o_bus = bus_r;

endmodule
`default_nettype wire

// *** core/sosq_top.sv ***
/*
  Single-operand cycle sequencer: fetch, decode, derivation, then the
  cycles of clear/set/invert/negate/increment/decrement, absolute value,
  execute-indirect, branch, branch-and-link and context switch.
  Assumes memory answers within each cycle on the same clock and that
  the status register value arrives on i_status.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sosq_defs.svh"

module sosq_top (
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Memory bus.
  output sosq_pkg::sosq_bus_t o_mem,
  input wire logic [15:0] i_rdata,
  // Processor state.
  input wire logic [15:0] i_status,
  output logic [15:0] o_pc,
  output logic [15:0] o_wp,
  output logic o_bad_op
);
  import sosq_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r, rst_n_r;

  // Assert at once, release after two edges so all state leaves reset together.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sosq_state_t st_r, st_nxt;
  sosq_bus_t bus_r, bus_nxt, der_bus;
  logic [15:0] pc_r, pc_nxt, wp_r, wp_nxt, ir_r, ir_nxt;
  logic [15:0] sa_r, sa_nxt, sv_r, sv_nxt, npc_r, npc_nxt;
  logic bad_r, bad_nxt, der_done, der_pc_adv;
  logic [9:0] op;
  logic is_modify;
  logic [15:0] mod_res;
  sosq_src_t src;

  assign op = ir_r[`SOSQ_OP_HI:`SOSQ_OP_LO];
  assign src = ir_r[`SOSQ_SRC_HI:`SOSQ_SRC_LO];
  assign is_modify = (op == `SOSQ_OP_CLEAR) || (op == `SOSQ_OP_SETONE) ||
                     (op == `SOSQ_OP_INVERT) || (op == `SOSQ_OP_NEGATE) ||
                     (op == `SOSQ_OP_INC) || (op == `SOSQ_OP_INC2) ||
                     (op == `SOSQ_OP_DEC) || (op == `SOSQ_OP_DEC2);

  // Derivation owns the bus only while the sequencer waits on it.
  assign o_mem = (st_r == S_DERIVE) ? der_bus : bus_r;

  sosq_derive u_derive (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n_r),
    .i_start(st_r == S_DECODE),
    .i_src(src),
    .i_wp(wp_r),
    .i_pc(pc_r),
    .i_rdata(i_rdata),
    .o_bus(der_bus),
    .o_done(der_done),
    .o_pc_adv(der_pc_adv)
  );

  // Result of the modify-in-place group.
  always_comb begin
    case (op)
      `SOSQ_OP_CLEAR: mod_res = `SOSQ_ZERO;
      `SOSQ_OP_SETONE: mod_res = `SOSQ_ALL_ONES;
      `SOSQ_OP_INVERT: mod_res = ~sv_r;
      `SOSQ_OP_NEGATE: mod_res = `SOSQ_ZERO - sv_r;
      `SOSQ_OP_INC: mod_res = sv_r + `SOSQ_ONE;
      `SOSQ_OP_INC2: mod_res = sv_r + `SOSQ_WORD_STEP;
      `SOSQ_OP_DEC: mod_res = sv_r - `SOSQ_ONE;
      `SOSQ_OP_DEC2: mod_res = sv_r - `SOSQ_WORD_STEP;
      default: mod_res = sv_r;
    endcase
  end

  // Next state; bus_nxt describes the cycle of st_nxt, so an idle cycle
  // keeps the address of whatever drove the bus last.
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    wp_nxt = wp_r;
    ir_nxt = ir_r;
    sa_nxt = sa_r;
    sv_nxt = sv_r;
    npc_nxt = npc_r;
    bad_nxt = 1'b0;
    bus_nxt = o_mem;
    bus_nxt.rd = 1'b0;
    bus_nxt.wr = 1'b0;
    case (st_r)
      S_FETCH: begin
        ir_nxt = i_rdata;
        pc_nxt = pc_r + `SOSQ_WORD_STEP;
        st_nxt = S_DECODE;
      end
      S_DECODE: st_nxt = S_DERIVE;
      S_DERIVE: begin
        if (der_pc_adv) begin
          pc_nxt = pc_r + `SOSQ_WORD_STEP;
        end
        if (der_done) begin
          sa_nxt = der_bus.addr;
          sv_nxt = i_rdata;
          st_nxt = S_EXEC;
        end
      end
      S_EXEC: begin
        if (is_modify) begin
          st_nxt = S_WRBACK;
          bus_nxt.wr = 1'b1;
          bus_nxt.addr = sa_r;
          bus_nxt.wdata = mod_res;
        end else begin
          case (op)
            `SOSQ_OP_ABS: st_nxt = S_ABS_TEST;
            `SOSQ_OP_EXEC: begin
              ir_nxt = sv_r;
              st_nxt = S_DECODE;
            end
            `SOSQ_OP_BRANCH: begin
              pc_nxt = sa_r;
              st_nxt = S_FETCH;
            end
            `SOSQ_OP_BLINK: begin
              st_nxt = S_BL_ADDR;
              bus_nxt.addr = sosq_wr_addr(wp_r, `SOSQ_WR_LINK);
            end
            `SOSQ_OP_CTXSW: begin
              st_nxt = S_CS_A15;
              bus_nxt.addr = sosq_wr_addr(sv_r, `SOSQ_WR_OLDST);
            end
            default: begin
              // Opcodes outside this group are flagged and skipped.
              bad_nxt = 1'b1;
              st_nxt = S_FETCH;
            end
          endcase
        end
      end
      S_WRBACK: st_nxt = S_FETCH;
      S_ABS_TEST: begin
        if (sv_r[`SOSQ_SIGN_BIT]) begin
          st_nxt = S_ABS_NEG;
        end else begin
          st_nxt = S_ABS_END;
        end
      end
      S_ABS_NEG: begin
        st_nxt = S_ABS_WR;
        bus_nxt.wr = 1'b1;
        bus_nxt.addr = sa_r;
        bus_nxt.wdata = `SOSQ_ZERO - sv_r;
      end
      S_ABS_WR: st_nxt = S_ABS_END;
      S_ABS_END: st_nxt = S_FETCH;
      S_BL_ADDR: begin
        st_nxt = S_BL_WR;
        bus_nxt.wr = 1'b1;
        bus_nxt.wdata = pc_r;
      end
      S_BL_WR: begin
        pc_nxt = sa_r;
        st_nxt = S_FETCH;
      end
      S_CS_A15: begin
        st_nxt = S_CS_W15;
        bus_nxt.wr = 1'b1;
        bus_nxt.wdata = i_status;
      end
      S_CS_W15: st_nxt = S_CS_I6;
      S_CS_I6: begin
        st_nxt = S_CS_W14;
        bus_nxt.wr = 1'b1;
        bus_nxt.addr = sosq_wr_addr(sv_r, `SOSQ_WR_OLDPC);
        bus_nxt.wdata = pc_r;
      end
      S_CS_W14: begin
        st_nxt = S_CS_A13;
        bus_nxt.addr = sosq_wr_addr(sv_r, `SOSQ_WR_OLDWP);
      end
      S_CS_A13: begin
        st_nxt = S_CS_W13;
        bus_nxt.wr = 1'b1;
        bus_nxt.wdata = wp_r;
      end
      S_CS_W13: st_nxt = S_CS_I10;
      S_CS_I10: begin
        st_nxt = S_CS_RDPC;
        bus_nxt.rd = 1'b1;
        bus_nxt.addr = sa_r + `SOSQ_WORD_STEP;
      end
      S_CS_RDPC: begin
        npc_nxt = i_rdata;
        st_nxt = S_CS_END;
      end
      S_CS_END: begin
        // The new context takes effect only after every save is done.
        wp_nxt = sv_r;
        pc_nxt = npc_r;
        st_nxt = S_FETCH;
      end
      default: st_nxt = S_FETCH;
    endcase
    // Every instruction opens with a read at the program counter.
    if (st_nxt == S_FETCH) begin
      bus_nxt.rd = 1'b1;
      bus_nxt.addr = pc_nxt;
    end
  end

  // State registers; reset leaves the bus already fetching at the reset PC.
  always_ff @(posedge i_core_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= S_FETCH;
      pc_r <= `SOSQ_RST_PC;
      wp_r <= `SOSQ_RST_WP;
      ir_r <= `SOSQ_ZERO;
      sa_r <= `SOSQ_ZERO;
      sv_r <= `SOSQ_ZERO;
      npc_r <= `SOSQ_ZERO;
      bad_r <= 1'b0;
      bus_r <= '{addr: `SOSQ_RST_PC, wdata: `SOSQ_ZERO, rd: 1'b1, wr: 1'b0};
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      wp_r <= wp_nxt;
      ir_r <= ir_nxt;
      sa_r <= sa_nxt;
      sv_r <= sv_nxt;
      npc_r <= npc_nxt;
      bad_r <= bad_nxt;
      bus_r <= bus_nxt;
    end
  end

  assign o_pc = pc_r;
  assign o_wp = wp_r;
  assign o_bad_op = bad_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_fetch_at_pc: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_FETCH |-> o_mem.rd && !o_mem.wr && o_mem.addr == pc_r ##1
    st_r == S_DECODE && !o_mem.rd && !o_mem.wr && $stable(o_mem.addr))
    else $error("fetch or decode cycle wrong");

  chk_derive_after_decode: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_DECODE |=> st_r == S_DERIVE && o_mem == der_bus)
    else $error("derivation not inserted after decode");

  chk_modify_writeback: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_EXEC && is_modify |-> !o_mem.rd && !o_mem.wr ##1
    o_mem.wr && o_mem.addr == sa_r ##1 st_r == S_FETCH)
    else $error("modify group write-back wrong");

  chk_clear_fetches: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_DERIVE && der_done |-> o_mem.rd)
    else $error("operand fetch skipped");

  chk_abs_skip: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_ABS_TEST && !sv_r[`SOSQ_SIGN_BIT] |=> st_r == S_ABS_END && !o_mem.wr)
    else $error("positive operand not skipped");

  chk_abs_negate: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_ABS_TEST && sv_r[`SOSQ_SIGN_BIT] |=> !o_mem.wr ##1
    o_mem.wr && o_mem.addr == sa_r && o_mem.wdata == `SOSQ_ZERO - sv_r)
    else $error("negated value not written");

  chk_abs_final_idle: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_ABS_END |-> !o_mem.rd && !o_mem.wr && $stable(o_mem.addr) ##1 st_r == S_FETCH)
    else $error("absolute value end cycle wrong");

  chk_exec_indirect: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_EXEC && op == `SOSQ_OP_EXEC |=> st_r == S_DECODE && ir_r == $past(sv_r))
    else $error("execute-indirect did not run operand");

  chk_branch_end: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_EXEC && op == `SOSQ_OP_BRANCH |-> !o_mem.rd && !o_mem.wr ##1
    st_r == S_FETCH && o_mem.addr == $past(sa_r))
    else $error("branch did not reach target");

  chk_link_write: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_BL_ADDR |-> o_mem.addr == sosq_wr_addr(wp_r, `SOSQ_WR_LINK) && !o_mem.wr ##1
    o_mem.wr && o_mem.wdata == pc_r ##1 st_r == S_FETCH && o_mem.addr == sa_r)
    else $error("link register write wrong");

  chk_ctx_status: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_CS_A15 |-> !o_mem.wr && o_mem.addr == sosq_wr_addr(sv_r, `SOSQ_WR_OLDST) ##1
    o_mem.wr && o_mem.wdata == $past(i_status))
    else $error("status save wrong");

  chk_ctx_return: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_CS_W15 |=> !o_mem.wr ##1
    o_mem.wr && o_mem.wdata == pc_r && o_mem.addr == sosq_wr_addr(sv_r, `SOSQ_WR_OLDPC))
    else $error("return address save wrong");

  chk_ctx_tail: assert property (@(posedge i_core_clk) disable iff (!rst_n_r)
    st_r == S_CS_W13 |-> o_mem.wr && o_mem.wdata == wp_r ##1 !o_mem.wr && !o_mem.rd ##1
    o_mem.rd && o_mem.addr == sa_r + `SOSQ_WORD_STEP ##1 !o_mem.rd ##1
    st_r == S_FETCH && wp_r == sv_r)
    else $error("context switch tail wrong");

endmodule
`default_nettype wire

// *** sim/sosq_mem.sv ***
/*
  Word memory on the sequencer bus, used as the far side in simulation.
  Assumes the sequencer's clock and zero wait states on every access.
*/
`timescale 1ns/1ps
`default_nettype none

module sosq_mem (
  // Clock.
  input wire logic i_core_clk,
  // Bus from the sequencer.
  input wire sosq_pkg::sosq_bus_t i_bus,
  output logic [15:0] o_rdata
);
  import sosq_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [15:0] mem [0:32767];
  logic [15:0] last_r = 16'h0000;

  // Reads answer within their cycle; otherwise the bus shows a flipped
  // pattern so that stale data is never taken for a real answer.
  always_comb begin
    o_rdata = i_bus.rd ? mem[i_bus.addr[15:1]] : ~last_r;
  end

  // Writes land at the end of their cycle; idle cycles touch nothing.
  always @(posedge i_core_clk) begin
    if (i_bus.wr) begin
      mem[i_bus.addr[15:1]] <= i_bus.wdata;
    end
    if (i_bus.rd) begin
      last_r <= o_rdata;
    end
  end

endmodule

`default_nettype wire

// *** sim/tb.sv ***
/*
  Self-checking bench of the single-operand sequencer.
  Assumes the program and workspace are preloaded before reset release.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sosq_defs.svh"

module tb;
  import sosq_pkg::*;

  typedef struct {sosq_bus_t b; int gap; string msg; logic [15:0] pc, wp; logic bad;} sosq_note_t;
  localparam logic [15:0] WP = 16'h0200;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] i_status = 16'h0000;
  logic [15:0] rdata, o_pc, o_wp, p, v, stat;
  logic [15:0] ewp = 16'h0000;
  logic ebad = 1'b0;
  logic o_bad_op;
  sosq_bus_t o_mem;
  sosq_note_t q[$];
  sosq_note_t cur;
  logic [15:0] sh [int];
  logic [9:0] ops [8] = '{`SOSQ_OP_CLEAR, `SOSQ_OP_SETONE, `SOSQ_OP_INVERT, `SOSQ_OP_NEGATE,
                         `SOSQ_OP_INC, `SOSQ_OP_INC2, `SOSQ_OP_DEC, `SOSQ_OP_DEC2};
  int g, n, gap = 0, bad_count = 0, total_checks = 0;

  sosq_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .o_mem(o_mem), .i_rdata(rdata),
                  .i_status(i_status), .o_pc(o_pc), .o_wp(o_wp), .o_bad_op(o_bad_op));
  sosq_mem u_mem (.i_core_clk(i_core_clk), .i_bus(o_mem), .o_rdata(rdata));

  // 100 MHz clock.
  initial begin
    forever #5 i_core_clk = ~i_core_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cmp16(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_int(string what, int exp, int got);
    total_checks++;
    if (got != exp) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic logic [15:0] ra(int r);
    return WP + 16'(2 * r);
  endfunction

  // Preloads memory and the bench's own picture of it.
  task automatic init(logic [15:0] a, logic [15:0] w);
    u_mem.mem[a[15:1]] = w;
    sh[a] = w;
  endtask

  // Notes one expected access and the idle cycles that precede it.
  task automatic note(logic rd, logic [15:0] a, logic [15:0] d, int gp);
    sosq_note_t x;
    x.b = '{addr: a, wdata: d, rd: rd, wr: !rd};
    x.gap = gp;
    x.msg = "";
    // Program counter, workspace pointer and skip flag expected during the access.
    x.pc = p;
    x.wp = ewp;
    x.bad = ebad;
    ebad = 1'b0;
    q.push_back(x);
    if (!rd) begin
      sh[a] = d;
    end
  endtask

  // Places one program word at the program counter and notes its read.
  task automatic prog(logic [15:0] w, int gp);
    init(p, w);
    note(1'b1, p, 16'h0000, gp);
    p = p + 16'h0002;
  endtask

  // Fetch at the program counter, decode, then a register-mode operand read.
  task automatic start(logic [9:0] op, logic [3:0] r);
    prog({op, 2'h0, r}, g);
    note(1'b1, ra(r), 16'h0000, 1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Program and expected bus cycles
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6fba));
    stat = 16'($urandom);
    // Context switch out of the reset workspace; the first fetch is not noted.
    init(16'h0000, {`SOSQ_OP_CTXSW, 2'h0, 4'h1});
    init(16'h0002, WP);
    init(16'h0004, 16'h0100);
    p = 16'h0002;
    note(1'b1, 16'h0002, 16'h0000, 1);
    note(1'b0, ra(15), stat, 2);
    note(1'b0, ra(14), 16'h0002, 1);
    note(1'b0, ra(13), 16'h0000, 1);
    note(1'b1, 16'h0004, 16'h0000, 1);
    q[$].msg = "context switch";
    ewp = WP;
    p = 16'h0100;
    g = 1;
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      init(ra(i + 1), v);
      start(ops[i], 4'(i + 1));
      case (i)
        0: v = 16'h0000;
        1: v = 16'hffff;
        2: v = ~v;
        3: v = -v;
        4: v = v + 16'h0001;
        5: v = v + 16'h0002;
        6: v = v - 16'h0001;
        default: v = v - 16'h0002;
      endcase
      note(1'b0, ra(i + 1), v, 1);
      g = 0;
    end
    q[$].msg = "modify group";
    // Absolute value of a positive, a negative and a zero operand.
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? {1'b0, 15'($urandom)} : (i == 1) ? {1'b1, 15'($urandom)} : 16'h0000;
      init(ra(9 + i), v);
      start(`SOSQ_OP_ABS, 4'(9 + i));
      // Test, jump and negate are three idle cycles; a positive operand idles
      // through test, jump and the final cycle.
      if (v[15]) begin
        note(1'b0, ra(9 + i), -v, 3);
        g = 1;
      end else begin
        g = 3;
      end
    end
    q[$].msg = "absolute value";
    // Execute-indirect of an increment held in register 12.
    init(ra(12), {`SOSQ_OP_INC, 2'h0, 4'h1});
    start(`SOSQ_OP_EXEC, 4'hc);
    note(1'b1, ra(1), 16'h0000, 2);
    note(1'b0, ra(1), sh[ra(1)] + 16'h0001, 1);
    q[$].msg = "execute indirect";
    g = 0;
    // Indirect and auto-increment through register 14, which holds the saved PC 2.
    prog({`SOSQ_OP_INC, `SOSQ_MODE_IND, 4'he}, 0);
    note(1'b1, ra(14), 16'h0000, 1);
    note(1'b1, 16'h0002, 16'h0000, 0);
    note(1'b0, 16'h0002, sh[2] + 16'h0001, 1);
    prog({`SOSQ_OP_DEC, `SOSQ_MODE_AUTO, 4'he}, 0);
    note(1'b1, ra(14), 16'h0000, 1);
    note(1'b0, ra(14), 16'h0004, 0);
    note(1'b1, 16'h0002, 16'h0000, 0);
    note(1'b0, 16'h0002, sh[2] - 16'h0001, 1);
    // Indexed by register 14, now 4, then indexed with no register.
    v = 16'($urandom);
    init(16'h0304, v);
    init(16'h0306, v);
    prog({`SOSQ_OP_INVERT, `SOSQ_MODE_IDX, 4'he}, 0);
    prog(16'h0300, 1);
    note(1'b1, ra(14), 16'h0000, 0);
    note(1'b1, 16'h0304, 16'h0000, 0);
    note(1'b0, 16'h0304, ~v, 1);
    prog({`SOSQ_OP_NEGATE, `SOSQ_MODE_IDX, 4'h0}, 0);
    prog(16'h0306, 1);
    note(1'b1, 16'h0306, 16'h0000, 0);
    note(1'b0, 16'h0306, -v, 1);
    q[$].msg = "source modes";
    // An opcode outside the group fetches its operand, idles once and is skipped.
    start(10'h3ff, 4'h1);
    q[$].msg = "bad opcode";
    g = 1;
    ebad = 1'b1;
    // Branch-and-link into register 0, which branches on to register 9.
    init(WP, {`SOSQ_OP_BRANCH, 2'h0, 4'h9});
    start(`SOSQ_OP_BLINK, 4'h0);
    note(1'b0, ra(11), p, 2);
    p = WP;
    g = 0;
    start(`SOSQ_OP_BRANCH, 4'h9);
    p = ra(9);
    note(1'b1, ra(9), 16'h0000, 1);
    q[$].msg = "branches";
    @(posedge i_core_clk);
    i_status <= stat;
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    n = 0;
    while (q.size() != 0 && n < 1000) begin
      @(posedge i_core_clk);
      n++;
    end
    if (q.size() != 0) begin
      bad_count++;
    end
    end_sim();
  end

  // Watchdog against a hung sequence.
  initial begin
    #50000;
    bad_count++;
    end_sim();
  end

  // Compares each memory access with the oldest note; idle cycles are counted.
  always @(negedge i_core_clk) begin
    if (!i_rst_n || (o_mem.rd === 1'b1 && o_mem.addr === 16'h0000 && o_pc === 16'h0000)) begin
      gap = 0;
    end else if ((o_mem.rd | o_mem.wr) === 1'b1) begin
      if (q.size() != 0) begin
        cur = q.pop_front();
        cmp16("kind", {14'h0, cur.b.rd, cur.b.wr}, {14'h0, o_mem.rd, o_mem.wr});
        cmp16("address", cur.b.addr, o_mem.addr);
        if (cur.b.wr) begin
          cmp16("write data", cur.b.wdata, o_mem.wdata);
        end
        cmp_int("idle cycles", cur.gap, gap);
        cmp16("bad op", {15'h0, cur.bad}, {15'h0, o_bad_op});
        cmp16("pc", cur.pc, o_pc);
        cmp16("wp", cur.wp, o_wp);
        if (cur.msg != "") begin
          $display("test %s done", cur.msg);
        end
      end
      gap = 0;
    end else begin
      gap++;
    end
  end

endmodule

`default_nettype wire
